// ==== odc_pkg.sv ====
// ****************************************************************
// ****************************************************************
package odc_pkg;
   // ****************************************************************
   // Command block layout
   // ****************************************************************
   localparam logic [7:0] ODC_OPCODE = 8'h40;       // Command operation code
   localparam int ODC_CDB_LEN = 10;                 // Command block length in bytes
   localparam int ODC_BYTE_LUN = 1;                 // Byte holding logical unit
   localparam int ODC_BYTE_SAVE = 2;                // Byte holding persist flag
   localparam int ODC_BYTE_SEL = 3;                 // Byte holding selector
   localparam int ODC_BYTE_LEN = 8;                 // Byte holding data length
   localparam int ODC_BYTE_CTL = 9;                 // Byte holding control
   localparam int ODC_LUN_MSB = 7;                  // Top bit of unit field
   localparam int ODC_LUN_LSB = 5;                  // Low bit of unit field
   localparam int ODC_SAVE_BIT = 0;                 // Persist flag position
   localparam int ODC_SEL_MSB = 6;                  // Top bit of selector field
   // ****************************************************************
   // Selector values
   // ****************************************************************
   localparam logic [6:0] ODC_SEL_KEEP = 7'h00;     // Keep current definition
   localparam logic [6:0] ODC_SEL_GEN1 = 7'h01;     // First generation
   localparam logic [6:0] ODC_SEL_CCS = 7'h02;      // Common command set
   localparam logic [6:0] ODC_SEL_GEN2 = 7'h03;     // Second generation
   localparam logic [6:0] ODC_SEL_VEND_LO = 7'h40;  // First vendor value
   localparam logic [6:0] ODC_DEF_RESET = 7'h03;    // Default definition value
   // ****************************************************************
   // Status codes and scopes
   // ****************************************************************
   localparam logic [7:0] ODC_ST_GOOD = 8'h00;      // Good status
   localparam logic [7:0] ODC_ST_CHECK = 8'h02;     // Check condition status
   localparam logic [7:0] ODC_SENSE_LEGACY = 8'h04; // Legacy zero-length sense size
   typedef enum logic [1:0] {
      ODC_SCOPE_LUN_ONE,                            // Per unit, issuing initiator
      ODC_SCOPE_TGT_ONE,                            // Whole target, issuing initiator
      ODC_SCOPE_LUN_ALL,                            // Per unit, all initiators
      ODC_SCOPE_TGT_ALL                             // Whole target, all initiators
   } odc_scope_t;

   // Legacy definitions relax the newer behaviours
   function automatic logic odc_is_legacy(input logic [6:0] def);
      odc_is_legacy = (def == ODC_SEL_GEN1) || (def == ODC_SEL_CCS);
   endfunction : odc_is_legacy
endpackage : odc_pkg

// ==== odc_link_if.sv ====
`timescale 1ns/10ps
// Byte-wide command link between initiator and target logic
interface odc_link_if;
   logic cmd_valid;          // Command byte strobe from initiator
   logic [7:0] cmd_byte;     // Command byte
   logic cmd_ready;          // Target takes command bytes
   logic dout_valid;         // Parameter byte strobe from initiator
   logic [7:0] dout_byte;    // Parameter byte
   logic dout_ready;         // Target takes parameter bytes
   logic status_valid;       // Status byte presented by target
   logic [7:0] status_byte;  // Status byte
   logic cc_ack;             // Acknowledge of command complete message
   modport target (input cmd_valid, cmd_byte, dout_valid, dout_byte, cc_ack,
                   output cmd_ready, dout_ready, status_valid, status_byte);
   modport initiator (output cmd_valid, cmd_byte, dout_valid, dout_byte, cc_ack,
                      input cmd_ready, dout_ready, status_valid, status_byte);
endinterface : odc_link_if

// ==== odc_target.sv ====
`timescale 1ns/10ps
module odc_target
   import odc_pkg::*;
#(
   parameter int NUM_INIT = 8,                           // Initiators tracked
   parameter int NUM_LUN = 8,                            // Logical units tracked
   parameter odc_scope_t SCOPE = ODC_SCOPE_TGT_ALL,      // Single scope in use
   parameter logic SAVE_SUPPORTED = 1'b1,                // Non-volatile store fitted
   parameter logic VENDOR_SUPPORTED = 1'b0               // Vendor selectors accepted
) (
   input wire logic clk,                                 // System clock
   input wire logic rst_n,                               // Async reset, active low
   odc_link_if.target link,                              // Command link
   input wire logic [2:0] init_id,                       // Issuing initiator number
   input wire logic [6:0] nv_def,                        // Stored definition value
   input wire logic nv_valid,                            // Stored value holds data
   input wire logic restore_fail,                        // Rollback could not complete
   output logic nv_write,                                // Pulse: store definition
   output logic [6:0] nv_wdata,                          // Definition to store
   output logic [6:0] cur_def,                           // Definition for issuing initiator
   output logic [NUM_INIT-1:0] ua_pending,               // Unit attention per initiator
   input wire logic [NUM_INIT-1:0] ua_clear,             // Unit attention clear per initiator
   output logic legacy_mode,                             // Legacy behaviour active
   output logic aen_enable,                              // Event notification allowed
   output logic eca_enable,                              // Extended allegiance allowed
   output logic [7:0] zero_sense_len,                    // Sense bytes for zero length
   output logic inq_features_clear                       // Inquiry feature bits cleared
);
   // ****************************************************************
   // Types and storage
   // ****************************************************************
   typedef enum {
      ST_CMD,       // Collect command bytes
      ST_DATA,      // Collect parameter bytes
      ST_STATUS,    // Present status
      ST_WAIT_ACK   // Wait for command complete acknowledge
   } odc_state_t;
   odc_state_t state_reg;                                // Sequencer state
   logic [7:0] cdb_reg [ODC_CDB_LEN];                    // Command block bytes
   logic [3:0] cnt_reg;                                  // Byte counter
   logic [7:0] len_reg;                                  // Remaining parameter bytes
   logic ok_reg;                                         // Command will succeed
   logic boot_reg;                                       // Reset load still pending
   // Definition table: one slot per initiator and unit
   logic [6:0] def_reg [NUM_INIT][NUM_LUN];
   logic [2:0] lun;                                      // Addressed unit
   logic [6:0] sel;                                      // Requested selector
   logic sel_ok;                                         // Selector is usable
   logic commit;                                         // Commit strobe
   logic cmd_good;                                       // Opcode and selector both usable
   logic [NUM_INIT-1:0] ua_set;                          // Attention sources this cycle

   assign lun = cdb_reg[ODC_BYTE_LUN][ODC_LUN_MSB:ODC_LUN_LSB];
   assign sel = cdb_reg[ODC_BYTE_SEL][ODC_SEL_MSB:0];

   // Selector check
   always_comb begin
      sel_ok = (sel <= ODC_SEL_GEN2);
      if (sel >= ODC_SEL_VEND_LO) begin
         sel_ok = VENDOR_SUPPORTED;
      end
   end

   // ****************************************************************
   // Command sequencer
   // ****************************************************************
   assign link.cmd_ready = (state_reg == ST_CMD);
   assign link.dout_ready = (state_reg == ST_DATA);
   assign link.status_valid = (state_reg == ST_STATUS);
   assign commit = (state_reg == ST_WAIT_ACK) && link.cc_ack && ok_reg;
   // Bytes 0 and 3 are stored well before the last command byte arrives
   assign cmd_good = (cdb_reg[0] == ODC_OPCODE) && sel_ok;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_CMD;
         cnt_reg <= 4'h0;
         len_reg <= 8'h00;
         ok_reg <= 1'b0;
         link.status_byte <= ODC_ST_GOOD;
      end else begin
         case (state_reg)
            ST_CMD: begin
               if (link.cmd_valid) begin
                  cdb_reg[cnt_reg] <= link.cmd_byte;
                  if (cnt_reg == 4'(ODC_CDB_LEN - 1)) begin
                     cnt_reg <= 4'h0;
                     len_reg <= cdb_reg[ODC_BYTE_LEN];
                     // opcode and selector check, accepted in any definition
                     ok_reg <= cmd_good;
                     // bad selector reports check
                     // Set early so the byte already stands while its strobe is up
                     link.status_byte <= cmd_good ? ODC_ST_GOOD : ODC_ST_CHECK;
                     state_reg <= (cdb_reg[ODC_BYTE_LEN] == 8'h00) ? ST_STATUS : ST_DATA;
                  end else begin
                     cnt_reg <= cnt_reg + 4'h1;
                  end
               end
            end
            ST_DATA: begin
               // Parameter data is vendor specific and is only counted here
               if (link.dout_valid) begin
                  len_reg <= len_reg - 8'h01;
                  if (len_reg == 8'h01) begin
                     state_reg <= ST_STATUS;
                  end
               end
            end
            ST_STATUS: begin
               // Status byte already stands; strobe lasts one cycle
               state_reg <= ST_WAIT_ACK;
            end
            default: begin
               if (link.cc_ack) begin
                  ok_reg <= 1'b0;
                  state_reg <= ST_CMD;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Definition table
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_reg <= 1'b1;
         for (int i = 0; i < NUM_INIT; i++) begin
            for (int j = 0; j < NUM_LUN; j++) begin
               def_reg[i][j] <= ODC_DEF_RESET;
            end
         end
      end else if (boot_reg) begin
         boot_reg <= 1'b0;
         for (int i = 0; i < NUM_INIT; i++) begin
            for (int j = 0; j < NUM_LUN; j++) begin
               def_reg[i][j] <= (SAVE_SUPPORTED && nv_valid) ? nv_def : ODC_DEF_RESET;
            end
         end
      end else if (commit && sel != ODC_SEL_KEEP) begin
         // single scope; table untouched unless committed
         for (int i = 0; i < NUM_INIT; i++) begin
            for (int j = 0; j < NUM_LUN; j++) begin
               case (SCOPE)
                  ODC_SCOPE_LUN_ONE: if (i == init_id && j == lun) def_reg[i][j] <= sel;
                  ODC_SCOPE_TGT_ONE: if (i == init_id) def_reg[i][j] <= sel;
                  ODC_SCOPE_LUN_ALL: if (j == lun) def_reg[i][j] <= sel;
                  default: def_reg[i][j] <= sel;
               endcase
            end
         end
      end
   end

   // Store request, one-cycle pulse in the cycle after commit
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nv_write <= 1'b0;
         nv_wdata <= ODC_DEF_RESET;
      end else begin
         nv_write <= commit && SAVE_SUPPORTED && cdb_reg[ODC_BYTE_SAVE][ODC_SAVE_BIT];
         nv_wdata <= (sel == ODC_SEL_KEEP) ? def_reg[init_id][lun] : sel;
      end
   end

   // ****************************************************************
   // Unit attention
   // ****************************************************************
   always_comb begin
      ua_set = '0;
      for (int i = 0; i < NUM_INIT; i++) begin
         if (commit && sel != ODC_SEL_KEEP &&
             (SCOPE == ODC_SCOPE_LUN_ALL || SCOPE == ODC_SCOPE_TGT_ALL || i == init_id)) begin
            ua_set[i] = 1'b1;
         end
         if (restore_fail && i == init_id) begin
            ua_set[i] = 1'b1;
         end
      end
   end

   // Set wins over clear so no notice is lost
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ua_pending <= '0;
      end else begin
         ua_pending <= (ua_pending & ~ua_clear) | ua_set;
      end
   end

   // ****************************************************************
   // Legacy behaviour controls
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cur_def <= ODC_DEF_RESET;
         legacy_mode <= 1'b0;
         aen_enable <= 1'b1;
         eca_enable <= 1'b1;
         zero_sense_len <= 8'h00;
         inq_features_clear <= 1'b0;
      end else begin
         cur_def <= def_reg[init_id][lun];
         legacy_mode <= odc_is_legacy(def_reg[init_id][lun]);
         aen_enable <= !odc_is_legacy(def_reg[init_id][lun]);
         eca_enable <= !odc_is_legacy(def_reg[init_id][lun]);
         zero_sense_len <= odc_is_legacy(def_reg[init_id][lun]) ? ODC_SENSE_LEGACY : 8'h00;
         inq_features_clear <= odc_is_legacy(def_reg[init_id][lun]);
      end
   end
endmodule : odc_target

// ==== odc_initiator.sv ====
`timescale 1ns/10ps
module odc_initiator
   import odc_pkg::*;
(
   input wire logic clk,                 // System clock
   input wire logic rst_n,               // Async reset, active low
   odc_link_if.initiator link,           // Command link
   input wire logic start,               // Pulse: issue command
   input wire logic [2:0] lun,           // Target unit
   input wire logic save,                // Persist flag
   input wire logic [6:0] sel,           // Definition selector
   input wire logic [7:0] plen,          // Parameter byte count
   input wire logic [7:0] pdata,         // Parameter byte value
   output logic busy,                    // Command in progress
   output logic done,                    // Pulse: command finished
   output logic [7:0] status,            // Returned status
   output logic verify_req               // Pulse: confirm via inquiry
);
   // ****************************************************************
   // Sequencer
   // ****************************************************************
   typedef enum {
      I_IDLE, I_CMD, I_DATA, I_STATUS, I_ACK
   } odc_istate_t;
   odc_istate_t state_reg;               // Sequencer state
   logic [3:0] cnt_reg;                  // Byte counter
   logic [7:0] len_reg;                  // Remaining parameter bytes
   logic [7:0] cdb [ODC_CDB_LEN];        // Command block image

   always_comb begin
      for (int k = 0; k < ODC_CDB_LEN; k++) begin
         cdb[k] = 8'h00;
      end
      cdb[0] = ODC_OPCODE;
      cdb[ODC_BYTE_LUN] = {lun, 5'h00};
      cdb[ODC_BYTE_SAVE] = {7'h00, save};
      cdb[ODC_BYTE_SEL] = {1'b0, sel};
      cdb[ODC_BYTE_LEN] = plen;
      cdb[ODC_BYTE_CTL] = 8'h00;
   end

   assign busy = (state_reg != I_IDLE);
   assign link.cmd_valid = (state_reg == I_CMD);
   assign link.dout_valid = (state_reg == I_DATA);
   assign link.cc_ack = (state_reg == I_ACK);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= I_IDLE;
         cnt_reg <= 4'h0;
         len_reg <= 8'h00;
         link.cmd_byte <= 8'h00;
         link.dout_byte <= 8'h00;
         status <= ODC_ST_GOOD;
         done <= 1'b0;
         verify_req <= 1'b0;
      end else begin
         done <= 1'b0;
         verify_req <= 1'b0;
         case (state_reg)
            I_IDLE: begin
               if (start) begin
                  cnt_reg <= 4'h0;
                  len_reg <= plen;
                  link.cmd_byte <= cdb[0];
                  state_reg <= I_CMD;
               end
            end
            I_CMD: begin
               if (link.cmd_ready) begin
                  if (cnt_reg == 4'(ODC_CDB_LEN - 1)) begin
                     // zero length has no data phase
                     state_reg <= (len_reg == 8'h00) ? I_STATUS : I_DATA;
                     link.dout_byte <= pdata;
                  end else begin
                     cnt_reg <= cnt_reg + 4'h1;
                     link.cmd_byte <= cdb[cnt_reg + 4'h1];
                  end
               end
            end
            I_DATA: begin
               if (link.dout_ready) begin
                  len_reg <= len_reg - 8'h01;
                  link.dout_byte <= pdata;
                  if (len_reg == 8'h01) begin
                     state_reg <= I_STATUS;
                  end
               end
            end
            I_STATUS: begin
               if (link.status_valid) begin
                  status <= link.status_byte;
                  state_reg <= I_ACK;
               end
            end
            default: begin
               done <= 1'b1;
               verify_req <= (status == ODC_ST_GOOD);
               state_reg <= I_IDLE;
            end
         endcase
      end
   end
endmodule : odc_initiator

// ==== odc_link_asserts.sv ====
`timescale 1ns/10ps
// ****************************************************************
// Link checker: watches the interface wires only
// ****************************************************************
module odc_link_asserts (
   input wire logic clk,             // Clock
   input wire logic rst_n,           // Async reset, active low
   input wire logic cmd_valid,       // Command strobe
   input wire logic [7:0] cmd_byte,  // Command byte
   input wire logic cmd_ready,       // Command accept
   input wire logic dout_valid,      // Data strobe
   input wire logic [7:0] dout_byte, // Data byte
   input wire logic dout_ready,      // Data accept
   input wire logic status_valid,    // Status strobe
   input wire logic [7:0] status_byte, // Status byte
   input wire logic cc_ack           // Complete acknowledge
);
   logic [3:0] cnt_reg;  // Command bytes taken
   logic [7:0] dcnt_reg; // Data bytes taken
   logic [7:0] len_reg;  // Captured data length
   logic [6:0] sel_reg;  // Captured selector

   // Byte counters restart at each acknowledge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         dcnt_reg <= 8'h00;
      end else if (cc_ack) begin
         cnt_reg <= 4'h0;
         dcnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + {3'h0, cmd_valid && cmd_ready};
         dcnt_reg <= dcnt_reg + {7'h00, dout_valid && dout_ready};
      end
   end

   // Field capture, so checks need not decode the block again
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         len_reg <= 8'h00;
         sel_reg <= 7'h00;
      end else if (cmd_valid && cmd_ready && cnt_reg == 4'h8) begin
         len_reg <= cmd_byte;
      end else if (cmd_valid && cmd_ready && cnt_reg == 4'h3) begin
         sel_reg <= cmd_byte[6:0];
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_opcode_first: assert property ((cmd_valid && cmd_ready && cnt_reg == 4'h0) |-> cmd_byte == 8'h40)
      else $error("first command byte is not the change opcode");
   a_ten_bytes: assert property (status_valid |-> cnt_reg == 4'hA)
      else $error("status without exactly ten command bytes");
   a_cmd_burst: assert property ($rose(cmd_valid) |-> cmd_valid[*8] ##1 cmd_valid[*2] ##1 !cmd_valid)
      else $error("command burst not ten cycles");
   a_ready_closed: assert property (cnt_reg == 4'hA |-> !cmd_ready)
      else $error("command accept open after block");
   a_data_count: assert property (status_valid |-> dcnt_reg == len_reg)
      else $error("data byte count differs from length");
   a_zero_nodata: assert property ((cnt_reg == 4'hA && len_reg == 8'h00) |-> !dout_valid)
      else $error("data sent with zero length");
   a_status_code: assert property (status_valid |->
      status_byte == ((sel_reg > 7'h03) ? 8'h02 : 8'h00))
      else $error("status code wrong for selector");
   a_ack_follows: assert property (status_valid |-> ##[1:3] cc_ack)
      else $error("no acknowledge after status");
   a_ack_pulse: assert property (cc_ack |=> !cc_ack)
      else $error("acknowledge longer than one cycle");
endmodule : odc_link_asserts

// ==== tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
   import odc_pkg::*;
   logic clk, rst_n, start, save, restore_fail, nv_valid, busy, done, nv_write, sv_d;
   logic legacy_mode, aen_enable, eca_enable, inq_features_clear, verify_req; // Level outputs and the verify_req pulse
   logic [2:0] lun, init_id;                // Unit and initiator
   logic [6:0] sel, nv_def, nv_wdata, cur_def;
   logic [7:0] plen, status, zero_sense_len, seen_st, ua_pending, ua_clear;
   logic [6:0] bad_sel [0:3];               // Refused selectors
   int n_errors, checks_done, nv_cnt, k;
   odc_link_if link();
   odc_initiator odc_initiator_inst (.clk(clk), .rst_n(rst_n), .link(link), .start(start),
      .lun(lun), .save(save), .sel(sel), .plen(plen), .pdata(8'hA5), .busy(busy), .done(done),
      .status(status), .verify_req(verify_req));
   odc_target odc_target_inst (.clk(clk), .rst_n(rst_n), .link(link), .init_id(init_id),
      .nv_def(nv_def), .nv_valid(nv_valid), .restore_fail(restore_fail), .nv_write(nv_write),
      .nv_wdata(nv_wdata), .cur_def(cur_def), .ua_pending(ua_pending), .ua_clear(ua_clear),
      .legacy_mode(legacy_mode), .aen_enable(aen_enable), .eca_enable(eca_enable),
      .zero_sense_len(zero_sense_len), .inq_features_clear(inq_features_clear));
   odc_link_asserts odc_link_asserts_inst (.clk(clk), .rst_n(rst_n), .cmd_valid(link.cmd_valid),
      .cmd_byte(link.cmd_byte), .cmd_ready(link.cmd_ready), .dout_valid(link.dout_valid),
      .dout_byte(link.dout_byte), .dout_ready(link.dout_ready), .status_valid(link.status_valid),
      .status_byte(link.status_byte), .cc_ack(link.cc_ack));

   // Clock: 100 MHz
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Status byte stands with its strobe; note the strobe to sample in the ack cycle
   always @(posedge clk) begin
      sv_d <= link.status_valid;
      if (nv_write) nv_cnt++;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task conclude;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   // Reset held five cycles; commands wait two edges after release
   task do_reset(input logic v, input logic [6:0] d);
      rst_n = 1'b0;
      nv_valid = v;
      nv_def = d;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
   endtask : do_reset

   task clr_ua;
      @(negedge clk);
      ua_clear = 8'hFF;
      @(negedge clk);
      ua_clear = 8'h00;
      @(negedge clk);
   endtask : clr_ua

   // One command; definition must not move before the acknowledge
   task run(input logic sv, input logic [6:0] s, input logic [7:0] n,
            input logic [7:0] exp_st, input logic [6:0] exp_def);
      int i;
      logic [6:0] old;
      old = cur_def;
      save = sv;
      sel = s;
      plen = n;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      for (i = 0; i < 60 && done !== 1'b1; i++) begin
         @(negedge clk);
         if (sv_d) begin
            seen_st = link.status_byte;
            chk("def before ack", {1'b0, old}, {1'b0, cur_def});
         end
      end
      if (done !== 1'b1) begin
         n_errors++;
         conclude();
      end
      chk("verify req", {7'h00, exp_st == ODC_ST_GOOD}, {7'h00, verify_req});
      repeat (3) @(negedge clk);
      chk("status", exp_st, seen_st);
      chk("init status", exp_st, status);
      chk("idle", 8'h00, {7'h00, busy});
      chk("def after", {1'b0, exp_def}, {1'b0, cur_def});
   endtask : run

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      {start, save, restore_fail} = 3'h0;
      {lun, init_id, sel, plen, ua_clear} = {3'h2, 3'h1, 7'h00, 8'h00, 8'h00};
      bad_sel = '{7'h04, 7'h3F, 7'h40, 7'h7F};
      do_reset(1'b1, 7'h01);
      chk("boot def", 8'h01, {1'b0, cur_def});
      chk("legacy", 8'h01, {7'h00, legacy_mode});
      chk("aen off", 8'h00, {7'h00, aen_enable});
      chk("eca off", 8'h00, {7'h00, eca_enable});
      chk("sense len", 8'h04, zero_sense_len);
      chk("inq clear", 8'h01, {7'h00, inq_features_clear});
      run(1'b0, 7'h03, 8'h00, 8'h00, 7'h03);
      chk("no store", 8'h00, nv_cnt[7:0]);
      chk("ua all", 8'hFF, ua_pending);
      chk("aen back", 8'h01, {7'h00, aen_enable});
      clr_ua();
      run(1'b1, 7'h02, 8'h03, 8'h00, 7'h02);
      chk("store count", 8'h01, nv_cnt[7:0]);
      chk("store value", 8'h02, {1'b0, nv_wdata});
      chk("ua scope", 8'hFF, ua_pending);
      clr_ua();
      run(1'b0, 7'h00, 8'h00, 8'h00, 7'h02);
      chk("keep no ua", 8'h00, ua_pending);
      run(1'b0, 7'h01, 8'h00, 8'h00, 7'h01);
      for (k = 0; k < 4; k++) run(1'b1, bad_sel[k], 8'h01, 8'h02, 7'h01);
      chk("no store bad", 8'h01, nv_cnt[7:0]);
      clr_ua();
      init_id = 3'h5;
      restore_fail = 1'b1;
      @(negedge clk);
      restore_fail = 1'b0;
      @(negedge clk);
      chk("ua restore", 8'h20, ua_pending);
      do_reset(1'b0, 7'h01);
      chk("default def", 8'h03, {1'b0, cur_def});
      conclude();
   end
endmodule : tb_top
